// >>> mac_collision_broadcast_pad_control.sv
// MAC control block: late collision, retry, broadcast reject and pad stripping logic
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/10ps

// Behaviour
// - With late collision retry set, a frame that collides late is retried like any other.
// - With late collision retry clear, a late collision abandons the frame at once.
// - A late collision is always flagged in the frame's transmit status.
// - With broadcast reject set, received broadcast frames are discarded, otherwise forwarded.
// - A matching wake-up frame wakes the device while wake detection is on, despite the reject.
// - With retry disable set, one attempt only; a collision drops the frame with a retry error, except a late one while late collision retry is clear.
// - With retry disable clear, a colliding frame gets up to 16 attempts before a retry error.
// - With pad stripping on and a length field below 46, pad and FCS are removed.
// - With pad stripping on and a length field of 46 or more, the frame passes unchanged.
// - With pad stripping off, every frame passes unchanged.
module mac_collision_broadcast_pad_control #(
  parameter int MAX_ATTEMPTS = mac_ctrl_pkg::MAX_ATTEMPTS
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     srst_i,
  // Avalon-MM register slave
  input  wire logic [4:0]               address_i,
  input  wire logic                     read_i,
  input  wire logic                     write_i,
  input  wire logic [31:0]              writedata_i,
  output logic      [31:0]              readdata_o,
  output logic                          waitrequest_o,
  // Transmit attempt events from the transmitter
  input  wire logic                     tx_start_i,
  input  wire logic                     tx_collision_i,
  input  wire logic                     tx_late_i,
  input  wire logic                     tx_ok_i,
  // Transmit commands and status
  output logic                          tx_retry_o,
  output logic                          tx_abort_o,
  output logic                          tx_status_valid_o,
  output mac_ctrl_pkg::tx_status_s      tx_status_o,
  // Receive stream in
  input  wire logic                     rx_valid_i,
  input  wire mac_ctrl_pkg::rx_beat_s   rx_beat_i,
  output logic                          rx_ready_o,
  // Receive stream out
  output logic                          rx_valid_o,
  output mac_ctrl_pkg::rx_beat_s        rx_beat_o,
  input  wire logic                     rx_ready_i,
  // Wake detector
  input  wire logic                     wake_frame_match_i,
  output logic                          wake_o,
  // Control levels to the rest of the MAC
  output logic                          rx_checksum_offload_en_o,
  output logic                          wake_frame_detect_en_o,
  // Interrupt
  output logic                          irq_o
);

  // Control bits
  logic                         late_collision_retry_en;
  logic                         broadcast_reject;
  logic                         retry_disable;
  logic                         pad_strip_en;
  logic                         rx_checksum_offload_en;
  logic                         wake_frame_detect_en;
  logic [mac_ctrl_pkg::INT_BITS-1:0] int_status;
  logic [mac_ctrl_pkg::INT_BITS-1:0] int_enable;
  logic [mac_ctrl_pkg::INT_BITS-1:0] int_events;
  logic                         read_done;
  logic [31:0]                  next_readdata;

  // Transmit state
  logic [4:0]                   attempts;
  logic                         late_seen;

  // Receive state
  mac_ctrl_pkg::rx_state_e      rx_state;
  logic [7:0]                   hdr [mac_ctrl_pkg::HDR_BYTES];
  logic [3:0]                   hdr_count;
  logic [3:0]                   emit_idx;
  logic [15:0]                  rx_pos;
  logic [15:0]                  keep_end;
  logic                         strip;
  logic                         frame_ended;
  logic                         in_take;
  logic                         out_free;
  logic                         hdr_done;
  logic                         is_broadcast_reject;
  logic                         emit_last;
  logic                         pass_last;
  logic                         pass_keep;

  // Reads the byte address as a register select
  function automatic logic sel(input logic [4:0] addr, input logic [4:0] ofs);
    return addr == ofs;
  endfunction

  // Combined write strobe for one register
  function automatic logic wr(input logic we, input logic [4:0] addr, input logic [4:0] ofs);
    return we && sel(addr, ofs);
  endfunction

  // Writes complete at once, reads after one wait cycle so readdata comes from a flop
  assign waitrequest_o = read_i && !read_done;

  // Read wait flag, pulses one cycle per read
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      read_done <= 1'b0;
    end else begin
      read_done <= read_i && !read_done;
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (sel(address_i, mac_ctrl_pkg::MAC_CR_OFS)) begin
      next_readdata[mac_ctrl_pkg::LATE_RETRY_BIT]   = late_collision_retry_en;
      next_readdata[mac_ctrl_pkg::BROADCAST_REJECT_REJECT_BIT] = broadcast_reject;
      next_readdata[mac_ctrl_pkg::RETRY_DIS_BIT]    = retry_disable;
      next_readdata[mac_ctrl_pkg::PAD_STRIP_BIT]    = pad_strip_en;
    end else if (sel(address_i, mac_ctrl_pkg::CSUM_CTRL_OFS)) begin
      next_readdata[mac_ctrl_pkg::RX_COE_BIT] = rx_checksum_offload_en;
    end else if (sel(address_i, mac_ctrl_pkg::WAKE_CSR_OFS)) begin
      next_readdata[mac_ctrl_pkg::WAKE_DET_BIT] = wake_frame_detect_en;
    end else if (sel(address_i, mac_ctrl_pkg::INT_STS_OFS)) begin
      next_readdata[mac_ctrl_pkg::INT_BITS-1:0] = int_status;
    end else if (sel(address_i, mac_ctrl_pkg::INT_EN_OFS)) begin
      next_readdata[mac_ctrl_pkg::INT_BITS-1:0] = int_enable;
    end
  end

  // Read data register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && !read_done) begin
      readdata_o <= next_readdata;
    end
  end

  // Control register writes; the reserved bit is never stored
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      late_collision_retry_en <= mac_ctrl_pkg::CTRL_BIT_RST;
      broadcast_reject        <= mac_ctrl_pkg::CTRL_BIT_RST;
      retry_disable           <= mac_ctrl_pkg::CTRL_BIT_RST;
      pad_strip_en            <= mac_ctrl_pkg::CTRL_BIT_RST;
      rx_checksum_offload_en  <= mac_ctrl_pkg::CTRL_BIT_RST;
      wake_frame_detect_en    <= mac_ctrl_pkg::CTRL_BIT_RST;
      int_enable              <= mac_ctrl_pkg::INT_RST;
    end else begin
      if (wr(write_i, address_i, mac_ctrl_pkg::MAC_CR_OFS)) begin
        late_collision_retry_en <= writedata_i[mac_ctrl_pkg::LATE_RETRY_BIT];
        broadcast_reject        <= writedata_i[mac_ctrl_pkg::BROADCAST_REJECT_REJECT_BIT];
        retry_disable           <= writedata_i[mac_ctrl_pkg::RETRY_DIS_BIT];
        pad_strip_en            <= writedata_i[mac_ctrl_pkg::PAD_STRIP_BIT];
      end
      // Exclusion with pad stripping is software's duty; both bits are stored as written
      if (wr(write_i, address_i, mac_ctrl_pkg::CSUM_CTRL_OFS)) begin
        rx_checksum_offload_en <= writedata_i[mac_ctrl_pkg::RX_COE_BIT];
      end
      if (wr(write_i, address_i, mac_ctrl_pkg::WAKE_CSR_OFS)) begin
        wake_frame_detect_en <= writedata_i[mac_ctrl_pkg::WAKE_DET_BIT];
      end
      if (wr(write_i, address_i, mac_ctrl_pkg::INT_EN_OFS)) begin
        int_enable <= writedata_i[mac_ctrl_pkg::INT_BITS-1:0];
      end
    end
  end

  assign rx_checksum_offload_en_o = rx_checksum_offload_en;
  assign wake_frame_detect_en_o   = wake_frame_detect_en;

  // Sticky status; a new event in the clearing cycle wins over the clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      int_status <= mac_ctrl_pkg::INT_RST;
    end else if (wr(write_i, address_i, mac_ctrl_pkg::INT_CLR_OFS)) begin
      int_status <= (int_status & ~writedata_i[mac_ctrl_pkg::INT_BITS-1:0]) | int_events;
    end else begin
      int_status <= int_status | int_events;
    end
  end

  assign irq_o = |(int_status & int_enable);

  // Transmit attempt bookkeeping: count attempts and note any late collision
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      attempts  <= 5'h00;
      late_seen <= 1'b0;
    end else if (tx_start_i) begin
      attempts  <= 5'h01;
      late_seen <= 1'b0;
    end else if (tx_collision_i) begin
      late_seen <= late_seen | tx_late_i;
      if (tx_retry_cond()) begin
        attempts <= attempts + 5'h01;
      end
    end
  end

  // Retry is allowed only if late policy, disable bit and attempt limit all permit it
  function automatic logic tx_retry_cond();
    if (tx_late_i && !late_collision_retry_en) begin
      return 1'b0;
    end
    if (retry_disable) begin
      return 1'b0;
    end
    return attempts < 5'(MAX_ATTEMPTS);
  endfunction

  // Transmit commands and per-frame status
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_retry_o        <= 1'b0;
      tx_abort_o        <= 1'b0;
      tx_status_valid_o <= 1'b0;
      tx_status_o       <= '0;
    end else begin
      tx_retry_o        <= 1'b0;
      tx_abort_o        <= 1'b0;
      tx_status_valid_o <= 1'b0;
      if (tx_collision_i) begin
        if (tx_retry_cond()) begin
          tx_retry_o <= 1'b1;
        end else begin
          tx_abort_o                 <= 1'b1;
          tx_status_valid_o          <= 1'b1;
          tx_status_o.late_collision <= late_seen | tx_late_i;
          // A late abort without retry is not a retry error
          tx_status_o.retry_error    <= !(tx_late_i && !late_collision_retry_en);
          tx_status_o.attempts       <= attempts;
        end
      end else if (tx_ok_i) begin
        tx_status_valid_o          <= 1'b1;
        tx_status_o.late_collision <= late_seen;
        tx_status_o.retry_error    <= 1'b0;
        tx_status_o.attempts       <= attempts;
      end
    end
  end

  // Receive handshake terms
  assign out_free  = !rx_valid_o || rx_ready_i;
  assign in_take   = rx_valid_i && rx_ready_o;
  assign hdr_done  = in_take && (rx_beat_i.last
                     || hdr_count == 4'(mac_ctrl_pkg::HDR_BYTES - 1));

  // Destination is broadcast when all six address bytes are ones; frames shorter than six bytes never are
  always_comb begin
    is_broadcast_reject = hdr_count >= 4'(mac_ctrl_pkg::DA_BYTES - 1);
    for (int i = 0; i < mac_ctrl_pkg::DA_BYTES - 1; i++) begin
      is_broadcast_reject = is_broadcast_reject && hdr[i] == mac_ctrl_pkg::BROADCAST_REJECT_BYTE;
    end
    if (hdr_count == 4'(mac_ctrl_pkg::DA_BYTES - 1)) begin
      is_broadcast_reject = is_broadcast_reject && rx_beat_i.data == mac_ctrl_pkg::BROADCAST_REJECT_BYTE;
    end else begin
      is_broadcast_reject = is_broadcast_reject && hdr[mac_ctrl_pkg::DA_BYTES - 1] == mac_ctrl_pkg::BROADCAST_REJECT_BYTE;
    end
  end

  // Ready toward the source; header holding is the only buffering
  always_comb begin
    case (rx_state)
      mac_ctrl_pkg::RX_HEADER: rx_ready_o = 1'b1;
      mac_ctrl_pkg::RX_PASS:   rx_ready_o = out_free;
      mac_ctrl_pkg::RX_DROP:   rx_ready_o = 1'b1;
      default:                 rx_ready_o = 1'b0;
    endcase
  end

  // Last-byte marks for the header replay and the pass-through phase
  assign emit_last = emit_idx == hdr_count - 4'h1
                     && (frame_ended || (strip && keep_end == 16'(mac_ctrl_pkg::HDR_BYTES)));
  assign pass_keep = !strip || rx_pos < keep_end;
  assign pass_last = rx_beat_i.last || (strip && rx_pos == keep_end - 16'h0001);

  // Header capture array
  always_ff @(posedge clock_i) begin
    if (rx_state == mac_ctrl_pkg::RX_HEADER && in_take) begin
      hdr[hdr_count] <= rx_beat_i.data;
    end
  end

  // Receive frame state machine
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_state    <= mac_ctrl_pkg::RX_HEADER;
      hdr_count   <= 4'h0;
      emit_idx    <= 4'h0;
      rx_pos      <= 16'h0000;
      keep_end    <= 16'h0000;
      strip       <= 1'b0;
      frame_ended <= 1'b0;
    end else begin
      case (rx_state)
        mac_ctrl_pkg::RX_HEADER: begin
          if (hdr_done) begin
            frame_ended <= rx_beat_i.last;
            emit_idx    <= 4'h0;
            rx_pos      <= 16'(mac_ctrl_pkg::HDR_BYTES);
            // Length is known only for a full header; short frames pass as they are
            strip       <= pad_strip_en && !rx_beat_i.last
                           && {hdr[12], rx_beat_i.data} < mac_ctrl_pkg::MIN_LEN_FIELD;
            keep_end    <= 16'(mac_ctrl_pkg::HDR_BYTES) + {hdr[12], rx_beat_i.data};
            hdr_count   <= hdr_count + 4'h1;
            if (broadcast_reject && is_broadcast_reject) begin
              rx_state  <= rx_beat_i.last ? mac_ctrl_pkg::RX_HEADER : mac_ctrl_pkg::RX_DROP;
              hdr_count <= 4'h0;
            end else begin
              rx_state  <= mac_ctrl_pkg::RX_EMIT;
            end
          end else if (in_take) begin
            hdr_count <= hdr_count + 4'h1;
          end
        end
        mac_ctrl_pkg::RX_EMIT: begin
          if (out_free) begin
            emit_idx <= emit_idx + 4'h1;
            if (emit_idx == hdr_count - 4'h1) begin
              hdr_count <= 4'h0;
              if (frame_ended) begin
                rx_state <= mac_ctrl_pkg::RX_HEADER;
              end else if (emit_last) begin
                rx_state <= mac_ctrl_pkg::RX_DROP;
              end else begin
                rx_state <= mac_ctrl_pkg::RX_PASS;
              end
            end
          end
        end
        mac_ctrl_pkg::RX_PASS: begin
          if (in_take) begin
            rx_pos <= rx_pos + 16'h0001;
            if (rx_beat_i.last) begin
              rx_state <= mac_ctrl_pkg::RX_HEADER;
            end else if (pass_last) begin
              rx_state <= mac_ctrl_pkg::RX_DROP;
            end
          end
        end
        default: begin
          // Swallow the rest of a rejected frame or the stripped pad and FCS
          if (in_take && rx_beat_i.last) begin
            rx_state <= mac_ctrl_pkg::RX_HEADER;
          end
        end
      endcase
    end
  end

  // Output byte register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_valid_o <= 1'b0;
      rx_beat_o  <= '0;
    end else if (out_free) begin
      rx_valid_o <= 1'b0;
      if (rx_state == mac_ctrl_pkg::RX_EMIT) begin
        rx_valid_o     <= 1'b1;
        rx_beat_o.data <= hdr[emit_idx];
        rx_beat_o.last <= emit_last;
      end else if (rx_state == mac_ctrl_pkg::RX_PASS && in_take && pass_keep) begin
        rx_valid_o     <= 1'b1;
        rx_beat_o.data <= rx_beat_i.data;
        rx_beat_o.last <= pass_last;
      end
    end
  end

  // Wake comes from the detector's own view of the raw frame, so the reject cannot hide it
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_frame_detect_en && wake_frame_match_i;
    end
  end

  // Interrupt event sources
  always_comb begin
    int_events = '0;
    int_events[mac_ctrl_pkg::INT_LATE_COLL_BIT]  = tx_collision_i && tx_late_i;
    int_events[mac_ctrl_pkg::INT_RETRY_ERR_BIT]  = tx_collision_i && !tx_retry_cond()
                                                   && !(tx_late_i && !late_collision_retry_en);
    int_events[mac_ctrl_pkg::INT_BROADCAST_REJECT_DROP_BIT] = rx_state == mac_ctrl_pkg::RX_HEADER
                                                   && hdr_done && broadcast_reject && is_broadcast_reject;
    int_events[mac_ctrl_pkg::INT_WAKE_BIT]       = wake_frame_detect_en && wake_frame_match_i;
  end

endmodule

// >>> mac_ctrl_pkg.sv
// Package with register map, field positions, reset values and carrier types of the MAC control block
package mac_ctrl_pkg;

  // Register byte offsets
  localparam logic [4:0] MAC_CR_OFS     = 5'h00;
  localparam logic [4:0] CSUM_CTRL_OFS  = 5'h04;
  localparam logic [4:0] WAKE_CSR_OFS   = 5'h08;
  localparam logic [4:0] INT_STS_OFS    = 5'h0C;
  localparam logic [4:0] INT_CLR_OFS    = 5'h10;
  localparam logic [4:0] INT_EN_OFS     = 5'h14;

  // MAC control register field positions
  localparam int LATE_RETRY_BIT    = 12;
  localparam int BROADCAST_REJECT_REJECT_BIT  = 11;
  localparam int RETRY_DIS_BIT     = 10;
  localparam int PAD_STRIP_BIT     = 8;
  // Checksum offload control and wake control field positions
  localparam int RX_COE_BIT        = 0;
  localparam int WAKE_DET_BIT      = 0;

  // Interrupt status bit positions
  localparam int INT_LATE_COLL_BIT = 0;
  localparam int INT_RETRY_ERR_BIT = 1;
  localparam int INT_BROADCAST_REJECT_DROP_BIT = 2;
  localparam int INT_WAKE_BIT      = 3;
  localparam int INT_BITS          = 4;

  // Reset values
  localparam logic [31:0] MAC_CR_RST    = 32'h0000_0000;
  localparam logic        CTRL_BIT_RST  = 1'b0;
  localparam logic [3:0]  INT_RST       = 4'h0;

  // Frame geometry and retry figures
  localparam int          MAX_ATTEMPTS  = 16;
  localparam int          DA_BYTES      = 6;
  localparam int          HDR_BYTES     = 14;
  localparam logic [15:0] MIN_LEN_FIELD = 16'h002E;  // 46 bytes
  localparam logic [7:0]  BROADCAST_REJECT_BYTE    = 8'hFF;

  // Per-frame transmit status handed to the transmit status path
  typedef struct packed {
    logic       late_collision;
    logic       retry_error;
    logic [4:0] attempts;
  } tx_status_s;

  // One byte of the receive stream
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rx_beat_s;

  // Receive path states
  typedef enum logic [1:0] {
    RX_HEADER,
    RX_EMIT,
    RX_PASS,
    RX_DROP
  } rx_state_e;

endpackage

// >>> phy_model.sv
// Receive side of the line partner: hands frame bytes to the block one by one
`timescale 1ns/10ps
module phy_model (
  // Clock
  input  wire logic              clock_i,
  // Byte stream towards the block
  input  wire logic              rx_ready_i,
  output logic                   rx_valid_o,
  output mac_ctrl_pkg::rx_beat_s rx_beat_o
);
  logic [7:0] frame [0:63];

  // Idle at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_beat_o  = '0;
  end

  // Each byte is held until an edge sees ready high
  task automatic send(input int n);
    @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      rx_valid_o <= 1'b1;
      rx_beat_o  <= '{data: frame[i], last: (i == n - 1)};
      do @(posedge clock_i); while (!rx_ready_i);
    end
    // Released data shows the inverse, so stale bytes never look valid
    rx_valid_o <= 1'b0;
    rx_beat_o  <= '{data: ~frame[n - 1], last: 1'b0};
  endtask
endmodule

// >>> mac_ctrl_monitor.sv
// Checker for transmit answers, wake pulses and output stream hold
`timescale 1ns/10ps
module mac_ctrl_monitor #(
  parameter int MAX_ATTEMPTS = 16
) (
  input wire logic                     clock_i,
  input wire logic                     srst_i,
  input wire logic                     tx_collision_i,
  input wire logic                     tx_late_i,
  input wire logic                     tx_ok_i,
  input wire logic                     tx_retry_o,
  input wire logic                     tx_abort_o,
  input wire logic                     tx_status_valid_o,
  input wire mac_ctrl_pkg::tx_status_s tx_status_o,
  input wire logic                     rx_valid_o,
  input wire mac_ctrl_pkg::rx_beat_s   rx_beat_o,
  input wire logic                     rx_ready_i,
  input wire logic                     wake_frame_match_i,
  input wire logic                     wake_o,
  input wire logic                     wake_frame_detect_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  a_late_abort_flag: assert property (
    tx_collision_i && tx_late_i |=> tx_retry_o || (tx_abort_o && tx_status_o.late_collision))
    else $error("late collision neither retried nor flagged");
  a_late_retry_path: assert property (
    (tx_collision_i && tx_late_i) ##1 tx_retry_o |-> !tx_abort_o && !tx_status_valid_o)
    else $error("late collision retried and aborted together");
  a_collision_answer: assert property (
    tx_collision_i |=> tx_retry_o != tx_abort_o)
    else $error("collision without exactly one answer");
  a_abort_status: assert property (
    tx_abort_o |-> tx_status_valid_o && (tx_status_o.retry_error || tx_status_o.late_collision))
    else $error("abort without a cause in status");
  a_retry_cap: assert property (
    tx_status_valid_o && tx_status_o.retry_error |->
      tx_status_o.attempts == 5'd1 || tx_status_o.attempts == MAX_ATTEMPTS[4:0])
    else $error("retry error at wrong attempt count");
  a_ok_status: assert property (
    tx_ok_i |=> tx_status_valid_o && !tx_status_o.retry_error && !tx_abort_o && !tx_retry_o)
    else $error("sent frame without clean status");
  a_wake_pulse: assert property (
    wake_frame_match_i |=> wake_o == $past(wake_frame_detect_en_o))
    else $error("wake pulse does not follow match and enable");
  a_out_hold: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_beat_o))
    else $error("output byte changed while stalled");
endmodule

bind mac_collision_broadcast_pad_control mac_ctrl_monitor #(.MAX_ATTEMPTS(MAX_ATTEMPTS)) mon_u (
  .clock_i(clock_i), .srst_i(srst_i), .tx_collision_i(tx_collision_i), .tx_late_i(tx_late_i),
  .tx_ok_i(tx_ok_i), .tx_retry_o(tx_retry_o), .tx_abort_o(tx_abort_o),
  .tx_status_valid_o(tx_status_valid_o), .tx_status_o(tx_status_o), .rx_valid_o(rx_valid_o),
  .rx_beat_o(rx_beat_o), .rx_ready_i(rx_ready_i), .wake_frame_match_i(wake_frame_match_i),
  .wake_o(wake_o), .wake_frame_detect_en_o(wake_frame_detect_en_o));

// >>> tb_top.sv
// Self-checking testbench for the MAC control block
`timescale 1ns/10ps
module tb_top;
  logic clock_i = 1'b0, srst_i = 1'b1, read_i = 1'b0, write_i = 1'b0, rx_ready_i = 1'b0;
  logic tx_start_i = 1'b0, tx_collision_i = 1'b0, tx_late_i = 1'b0, tx_ok_i = 1'b0;
  logic wake_frame_match_i = 1'b0;
  logic [4:0]  address_i = 5'h00;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [31:0] readdata_o, rd;
  logic waitrequest_o, tx_retry_o, tx_abort_o, tx_status_valid_o, rx_ready_o, rx_valid_o;
  logic wake_o, rx_checksum_offload_en_o, wake_frame_detect_en_o, irq_o, rx_valid_i;
  logic retry_c, abort_c, sv_c, wake_c;
  logic [6:0]  st_c;
  logic [2:0]  stall = 3'h0;
  mac_ctrl_pkg::tx_status_s tx_status_o;
  mac_ctrl_pkg::rx_beat_s   rx_beat_i, rx_beat_o;
  mac_ctrl_pkg::rx_beat_s   out_q[$];
  int errors = 0;
  int num_checks = 0;

  mac_collision_broadcast_pad_control dut_u (
    .clock_i(clock_i), .srst_i(srst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .tx_start_i(tx_start_i), .tx_collision_i(tx_collision_i),
    .tx_late_i(tx_late_i), .tx_ok_i(tx_ok_i), .tx_retry_o(tx_retry_o), .tx_abort_o(tx_abort_o),
    .tx_status_valid_o(tx_status_valid_o), .tx_status_o(tx_status_o), .rx_valid_i(rx_valid_i),
    .rx_beat_i(rx_beat_i), .rx_ready_o(rx_ready_o), .rx_valid_o(rx_valid_o),
    .rx_beat_o(rx_beat_o), .rx_ready_i(rx_ready_i), .wake_frame_match_i(wake_frame_match_i),
    .wake_o(wake_o), .rx_checksum_offload_en_o(rx_checksum_offload_en_o),
    .wake_frame_detect_en_o(wake_frame_detect_en_o), .irq_o(irq_o));

  phy_model phy_u (.clock_i(clock_i), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
    .rx_beat_o(rx_beat_i));

  // Clock of 10 ns
  always #5 clock_i = ~clock_i;

  // Sink stalls one cycle in eight to exercise the hold path
  always @(posedge clock_i) begin
    stall <= stall + 3'h1;
    rx_ready_i <= (stall != 3'h5);
    if (rx_valid_o && rx_ready_i) out_q.push_back(rx_beat_o);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    write_i <= 1'b1; address_i <= a; writedata_i <= d;
    do @(posedge clock_i); while (waitrequest_o);
    write_i <= 1'b0;
  endtask

  task automatic bus_read(input logic [4:0] a);
    @(posedge clock_i);
    read_i <= 1'b1; address_i <= a;
    do @(posedge clock_i); while (waitrequest_o);
    rd = readdata_o;
    read_i <= 1'b0;
  endtask

  // One event pulse (0 start, 1 collision, 2 late collision, 3 sent, 4 wake match)
  task automatic pulse(input int k);
    @(posedge clock_i);
    tx_start_i <= (k == 0); tx_collision_i <= (k == 1 || k == 2); tx_late_i <= (k == 2);
    tx_ok_i <= (k == 3); wake_frame_match_i <= (k == 4);
    @(posedge clock_i);
    {tx_start_i, tx_collision_i, tx_late_i, tx_ok_i, wake_frame_match_i} <= 5'h00;
    @(posedge clock_i);
    {retry_c, abort_c, sv_c, wake_c, st_c} =
      {tx_retry_o, tx_abort_o, tx_status_valid_o, wake_o, tx_status_o};
  endtask

  task automatic fill_send(input logic bc, input logic [15:0] len, input int n);
    for (int i = 0; i < n; i++) phy_u.frame[i] = (bc && i < 6) ? 8'hFF : 8'h20 + i[7:0];
    phy_u.frame[12] = len[15:8];
    phy_u.frame[13] = len[7:0];
    phy_u.send(n);
  endtask

  // Waits for keep bytes, then matches them against the last frame sent
  task automatic expect_out(input int keep);
    for (int w = 0; w < 1000 && out_q.size() < keep; w++) @(posedge clock_i);
    chk(out_q.size(), keep);
    for (int i = 0; i < keep && i < out_q.size(); i++)
      chk({out_q[i].data, out_q[i].last}, {phy_u.frame[i], 1'b0 + (i == keep - 1)});
    out_q.delete();
  endtask

  task automatic t_regs();
    bus_read(mac_ctrl_pkg::MAC_CR_OFS); chk(rd, 32'h0000_0000);
    bus_write(mac_ctrl_pkg::CSUM_CTRL_OFS, 32'hFFFF_FFFF);
    bus_read(mac_ctrl_pkg::CSUM_CTRL_OFS); chk(rd, 32'h0000_0001);
    chk(rx_checksum_offload_en_o, 1'b1);
    bus_write(mac_ctrl_pkg::CSUM_CTRL_OFS, 32'h0000_0000);
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'hFFFF_FFFF);
    bus_read(mac_ctrl_pkg::MAC_CR_OFS); chk(rd, 32'h0000_1D00);
    bus_read(5'h18); chk(rd, 32'h0000_0000);
  endtask

  task automatic t_retry();
    bus_write(mac_ctrl_pkg::INT_CLR_OFS, 32'h0000_000F);
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_0000);
    pulse(0);
    repeat (15) begin pulse(1); chk({retry_c, abort_c}, 2'b10); end
    pulse(1); chk({abort_c, sv_c, st_c}, {2'b11, 7'b0110000});
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_0400);
    pulse(0); pulse(1); chk({retry_c, abort_c, sv_c, st_c}, {3'b011, 7'b0100001});
    bus_read(mac_ctrl_pkg::INT_STS_OFS); chk(rd, 32'h0000_0002);
    @(posedge clock_i); chk(irq_o, 1'b0);
    bus_write(mac_ctrl_pkg::INT_EN_OFS, 32'h0000_0002);
    @(posedge clock_i); chk(irq_o, 1'b1);
    bus_write(mac_ctrl_pkg::INT_CLR_OFS, 32'h0000_0002);
    @(posedge clock_i); chk(irq_o, 1'b0);
  endtask

  task automatic t_late();
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_0000);
    pulse(0); pulse(2); chk({retry_c, abort_c, sv_c, st_c}, {3'b011, 7'b1000001});
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_1000);
    pulse(0); pulse(2); chk({retry_c, abort_c, sv_c}, 3'b100);
    pulse(3); chk({sv_c, st_c}, {1'b1, 7'b1000010});
  endtask

  task automatic t_broadcast_reject();
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_0800);
    out_q.delete();
    fill_send(1'b1, 16'h002E, 60);
    fill_send(1'b0, 16'h002E, 60);
    expect_out(60);
    bus_read(mac_ctrl_pkg::INT_STS_OFS); chk(rd & 32'h4, 32'h4);
    bus_write(mac_ctrl_pkg::WAKE_CSR_OFS, 32'h0000_0001);
    pulse(4); chk(wake_c, 1'b1);
    bus_write(mac_ctrl_pkg::WAKE_CSR_OFS, 32'h0000_0000);
    pulse(4); chk(wake_c, 1'b0);
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_0000);
    fill_send(1'b1, 16'h002E, 60);
    expect_out(60);
  endtask

  task automatic t_pad();
    // Offload goes off before stripping comes on; the two never run together
    bus_write(mac_ctrl_pkg::CSUM_CTRL_OFS, 32'h0000_0000);
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_0100);
    out_q.delete();
    fill_send(1'b0, 16'h0004, 60);
    expect_out(18);
    fill_send(1'b0, 16'h002E, 64);
    expect_out(64);
    bus_write(mac_ctrl_pkg::MAC_CR_OFS, 32'h0000_0000);
    fill_send(1'b0, 16'h0004, 60);
    expect_out(60);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    t_regs();
    t_retry();
    t_late();
    t_broadcast_reject();
    t_pad();
    test_done();
  end

  // Watchdog, well beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    test_done();
  end
endmodule
